// file: cpio_defs.svh
// Constants for the clock, power-down and dual-role pin block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef CPIO_DEFS_SVH
`define CPIO_DEFS_SVH
`define CPIO_CLK_HZ        20000000
`define CPIO_MCLK_HZ       8000000
`define CPIO_FRAC_UNIT     4000000
`define CPIO_MCLK_NUM      (`CPIO_MCLK_HZ / `CPIO_FRAC_UNIT)
`define CPIO_MCLK_DEN      (`CPIO_CLK_HZ / `CPIO_FRAC_UNIT)
`define CPIO_PRESCALE      32
`define CPIO_TMR_MIN_US    32
`define CPIO_TMR_MAX_MS    1960
`define CPIO_TICK_HZ       (`CPIO_MCLK_HZ / `CPIO_PRESCALE)
`define CPIO_TMR_MIN_TICKS (`CPIO_TMR_MIN_US * `CPIO_TICK_HZ / 1000000)
`define CPIO_TMR_MAX_TICKS (`CPIO_TMR_MAX_MS * (`CPIO_TICK_HZ / 1000))
`define CPIO_WAKE_RST_CYC  4
`define CPIO_NPIN          5
`define CPIO_NTMR          4
`define CPIO_OFS_CFG       32'h00
`define CPIO_OFS_CTRL      32'h04
`define CPIO_OFS_ROUTE     32'h08
`define CPIO_OFS_STAT      32'h0c
`define CPIO_OFS_SIG       32'h10
`define CPIO_OFS_TMR0      32'h14
`define CPIO_CFG_EN_BIT    0
`define CPIO_CFG_SRC_BIT   1
`define CPIO_CFG_DIR_LSB   2
`define CPIO_CTRL_REQ_BIT  0
`define CPIO_CTRL_MAC_LSB  8
`define CPIO_TMR_START_BIT 8
`define CPIO_TMR_BUSY_BIT  16
`define CPIO_TMR_DONE_BIT  17
`define CPIO_STAT_DIN_LSB  0
`define CPIO_STAT_ARR_LSB  2
`define CPIO_STAT_PM_LSB   7
`define CPIO_STAT_DONE_LSB 9
`define CPIO_SIG_RESET     32'h0000_0000
`define CPIO_RESP_OKAY     2'b00
`define CPIO_RESP_SLVERR   2'b10
`endif

// file: cpio_pkg.sv
// Types shared by the block's modules.
// Assumes cpio_defs.svh is on the include path.
package cpio_pkg;
  `include "cpio_defs.svh"
  typedef enum logic [1:0] {
    CPIO_INIT   = 2'b00,
    CPIO_NORMAL = 2'b01,
    CPIO_PDOWN  = 2'b10,
    CPIO_WAKE   = 2'b11
  } cpio_pm_e;
  typedef logic [6:0] cpio_tsel_t;
endpackage : cpio_pkg

// file: cpio_tmr_if.sv
// Carrier between the top module and one programmable timer.
// Assumes both ends share one clock.
interface cpio_tmr_if;
  import cpio_pkg::*;
  logic       start;
  logic       clr;
  logic       tick;
  cpio_tsel_t setting;
  logic       busy;
  logic       done;
  modport ctl (output start, output clr, output tick, output setting, input busy, input done);
  modport tmr (input start, input clr, input tick, input setting, output busy, output done);
endinterface : cpio_tmr_if

// file: cpio_timer.sv
// One programmable timer counting prescaled ticks.
// Assumes tick is a one-cycle enable at the prescaled rate.
`include "cpio_defs.svh"
module cpio_timer
  import cpio_pkg::*;
#(
  parameter int unsigned MAX_TICKS = `CPIO_TMR_MAX_TICKS
) (
  input  wire logic clk,
  input  wire logic arst_n,
  cpio_tmr_if.tmr   tif
);
  logic [31:0] span;
  logic [31:0] limit;
  logic [31:0] cnt_reg;
  logic        busy_reg;
  logic        done_reg;

  // Mantissa and exponent give 128 settings; the longest ones clamp at the ceiling.
  assign span  = ({28'h0, tif.setting[3:0]} + 32'h1) << (5'(tif.setting[6:4]) * 5'h2 + 5'h3);
  assign limit = (span > 32'(MAX_TICKS)) ? 32'(MAX_TICKS) : span;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg  <= 32'h0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (tif.clr) begin
      cnt_reg  <= 32'h0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (tif.start) begin
      cnt_reg  <= 32'h0;
      busy_reg <= 1'b1;
      done_reg <= 1'b0;
    end else if (busy_reg && tif.tick) begin
      cnt_reg <= cnt_reg + 32'h1;
      if (cnt_reg + 32'h1 >= limit) begin
        busy_reg <= 1'b0;
        done_reg <= 1'b1;
      end
    end
  end

  assign tif.busy = busy_reg;
  assign tif.done = done_reg;
endmodule : cpio_timer

// file: cpio_top.sv
// Clock prescaler, four timers, power-down control and five dual-role pins.
// Assumes an AXI4-Lite master on clk; pins arrive asynchronously.
`include "cpio_defs.svh"
module cpio_top
  import cpio_pkg::*;
#(
  parameter int unsigned TMR_MAX_TICKS = `CPIO_TMR_MAX_TICKS
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        wake_sleep_pin,
  input  wire logic [1:0]  din_pin,
  input  wire logic [4:0]  io_pin_i,
  output logic [4:0]       io_pin_o,
  output logic [4:0]       io_pin_oe,
  output logic             power_down
);
  localparam int NP = `CPIO_NPIN;
  localparam int NT = `CPIO_NTMR;
  cpio_pm_e    pm_reg;
  cpio_pm_e    pm_next;
  logic [2:0]  wrst_reg;
  logic        awake;
  logic        logic_rst;
  logic        pd_cond;
  logic [2:0]  frac_reg;
  logic        mclk_en;
  logic [4:0]  pre_reg;
  logic        tick_en;
  logic        wake_s1_reg, wake_s2_reg;
  logic [1:0]  din_s1_reg, din_s2_reg;
  logic [4:0]  io_s1_reg, io_s2_reg;
  logic [1:0]  din_reg;
  logic [4:0]  ioin_reg;
  logic        sleep_enable_cfg;
  logic        sleep_source_cfg;
  logic [4:0]  io_dir_reg;
  logic [31:0] user_signature;
  logic        logic_sleep_request;
  logic [4:0]  macro_reg;
  logic [14:0] route_reg;
  cpio_tsel_t  tsel_reg [NT];
  logic [NT-1:0] tstart;
  logic [NT-1:0] tbusy;
  logic [NT-1:0] tdone;
  logic [4:0]  array_in;
  logic [4:0]  pin_drive;

  // Power mode control. The pin synchronisers, the bus and this state run on the
  // free clock; the oscillator enables below stop while powered down.
  assign awake   = (pm_reg == CPIO_NORMAL);
  assign pd_cond = sleep_enable_cfg && !wake_s2_reg &&
                   (!sleep_source_cfg || !logic_sleep_request);
  assign logic_rst = (pm_reg != CPIO_NORMAL);
  assign power_down = (pm_reg == CPIO_PDOWN);

  always_comb begin
    pm_next = pm_reg;
    case (pm_reg)
      CPIO_INIT:   pm_next = pd_cond ? CPIO_PDOWN : CPIO_NORMAL;
      CPIO_NORMAL: pm_next = pd_cond ? CPIO_PDOWN : CPIO_NORMAL;
      CPIO_PDOWN:  pm_next = wake_s2_reg ? CPIO_WAKE : CPIO_PDOWN;
      CPIO_WAKE:   pm_next = (wrst_reg == 3'(`CPIO_WAKE_RST_CYC - 1)) ? CPIO_NORMAL : CPIO_WAKE;
      default:     pm_next = CPIO_INIT;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pm_reg   <= CPIO_INIT;
      wrst_reg <= 3'h0;
    end else begin
      pm_reg   <= pm_next;
      wrst_reg <= (pm_reg == CPIO_WAKE) ? wrst_reg + 3'h1 : 3'h0;
    end
  end

  // The 8 MHz master clock is two enables in every five 20 MHz cycles.
  assign mclk_en = awake && (frac_reg + 3'(`CPIO_MCLK_NUM) >= 3'(`CPIO_MCLK_DEN));
  assign tick_en = mclk_en && (pre_reg == 5'(`CPIO_PRESCALE - 1));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      frac_reg <= 3'h0;
      pre_reg  <= 5'h0;
    end else if (!awake) begin
      frac_reg <= 3'h0;
      pre_reg  <= 5'h0;
    end else begin
      frac_reg <= mclk_en ? frac_reg + 3'(`CPIO_MCLK_NUM) - 3'(`CPIO_MCLK_DEN)
                          : frac_reg + 3'(`CPIO_MCLK_NUM);
      if (mclk_en) begin
        pre_reg <= pre_reg + 5'h1;
      end
    end
  end

  // Input path: two flip-flops for metastability, then the master-clock register.
  // The wake synchroniser keeps running: it is the only pin still watched asleep.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_s1_reg <= 1'b0;
      wake_s2_reg <= 1'b0;
      din_s1_reg  <= 2'h0;
      din_s2_reg  <= 2'h0;
      io_s1_reg   <= 5'h0;
      io_s2_reg   <= 5'h0;
    end else begin
      wake_s1_reg <= wake_sleep_pin;
      wake_s2_reg <= wake_s1_reg;
      din_s1_reg  <= din_pin;
      din_s2_reg  <= din_s1_reg;
      io_s1_reg   <= io_pin_i;
      io_s2_reg   <= io_s1_reg;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      din_reg  <= 2'h0;
      ioin_reg <= 5'h0;
    end else if (logic_rst) begin
      din_reg  <= 2'h0;
      ioin_reg <= 5'h0;
    end else if (mclk_en) begin
      din_reg  <= din_s2_reg;
      ioin_reg <= io_s2_reg & ~io_dir_reg;
    end
  end

  // Dual-role pins. A macrocell whose own pin is an input can still be routed out.
  generate
    for (genvar i = 0; i < NP; i++) begin : g_pin
      logic [2:0] sel;
      assign sel          = route_reg[3*i +: 3];
      assign pin_drive[i] = (sel < 3'(NP)) ? macro_reg[sel] : macro_reg[i];
      assign array_in[i]  = io_dir_reg[i] ? macro_reg[i] : ioin_reg[i];
      assign io_pin_oe[i] = awake && io_dir_reg[i] && !pin_drive[i];
      assign io_pin_o[i]  = 1'b0;
    end
  endgenerate

  // AXI4-Lite write side: address and data are taken in either order.
  logic        aw_held_reg, w_held_reg, bvalid_reg;
  logic [31:0] awaddr_reg, wdata_reg, wr_tofs;
  logic [1:0]  bresp_reg;
  logic        wr_fire, wr_hit, wr_tmr;
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_tofs = awaddr_reg - `CPIO_OFS_TMR0;
  assign wr_tmr  = (awaddr_reg >= `CPIO_OFS_TMR0) && (wr_tofs[31:2] < 30'(NT));
  assign wr_hit  = wr_tmr || (awaddr_reg[31:2] <= 30'(`CPIO_OFS_SIG >> 2));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= 32'h0;
      wdata_reg   <= 32'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `CPIO_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= {s_axi_awaddr[31:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        for (int b = 0; b < 4; b++) begin
          wdata_reg[8*b +: 8] <= s_axi_wstrb[b] ? s_axi_wdata[8*b +: 8] : 8'h00;
        end
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_hit ? `CPIO_RESP_OKAY : `CPIO_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Nonvolatile configuration survives power-down; the bus stands in for the
  // serial programming port, so these fields only clear on the external reset.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sleep_enable_cfg <= 1'b0;
      sleep_source_cfg <= 1'b0;
      io_dir_reg       <= 5'h0;
      user_signature   <= `CPIO_SIG_RESET;
    end else if (wr_fire && awaddr_reg == `CPIO_OFS_CFG) begin
      sleep_enable_cfg <= wdata_reg[`CPIO_CFG_EN_BIT];
      sleep_source_cfg <= wdata_reg[`CPIO_CFG_SRC_BIT];
      io_dir_reg       <= wdata_reg[`CPIO_CFG_DIR_LSB +: 5];
    end else if (wr_fire && awaddr_reg == `CPIO_OFS_SIG) begin
      user_signature   <= wdata_reg;
    end
  end

  // Logic-array state is volatile: it is lost in power-down and on wake-up.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      logic_sleep_request <= 1'b0;
      macro_reg           <= 5'h0;
      route_reg           <= 15'h7fff;
    end else if (logic_rst) begin
      logic_sleep_request <= 1'b0;
      macro_reg           <= 5'h0;
      route_reg           <= 15'h7fff;
    end else if (wr_fire && awaddr_reg == `CPIO_OFS_CTRL) begin
      logic_sleep_request <= wdata_reg[`CPIO_CTRL_REQ_BIT];
      macro_reg           <= wdata_reg[`CPIO_CTRL_MAC_LSB +: 5];
    end else if (wr_fire && awaddr_reg == `CPIO_OFS_ROUTE) begin
      route_reg           <= wdata_reg[14:0];
    end
  end

  // Timers run only while awake, on the prescaled tick.
  generate
    for (genvar t = 0; t < NT; t++) begin : g_tmr
      cpio_tmr_if tif ();
      assign tstart[t] = awake && wr_fire && wdata_reg[`CPIO_TMR_START_BIT] &&
                         (awaddr_reg == `CPIO_OFS_TMR0 + 32'(4 * t));
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          tsel_reg[t] <= '0;
        end else if (logic_rst) begin
          tsel_reg[t] <= '0;
        end else if (wr_fire && awaddr_reg == `CPIO_OFS_TMR0 + 32'(4 * t)) begin
          tsel_reg[t] <= wdata_reg[6:0];
        end
      end
      assign tif.start   = tstart[t];
      assign tif.clr     = logic_rst;
      assign tif.tick    = tick_en;
      assign tif.setting = tsel_reg[t];
      assign tbusy[t]    = tif.busy;
      assign tdone[t]    = tif.done;
      cpio_timer #(.MAX_TICKS(TMR_MAX_TICKS)) u_tmr (
        .clk    (clk),
        .arst_n (arst_n),
        .tif    (tif.tmr)
      );
    end
  endgenerate
  // AXI4-Lite read side: one request at a time, answered on the next edge.
  logic        rvalid_reg, rd_tmr, rd_hit;
  logic [31:0] rdata_reg, rd_addr, rd_tofs, rd_word, stat_word;
  logic [1:0]  rresp_reg, rd_tidx;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign rd_addr = {s_axi_araddr[31:2], 2'b00};
  assign rd_tofs = rd_addr - `CPIO_OFS_TMR0;
  assign rd_tidx = rd_tofs[3:2];
  assign rd_tmr  = (rd_addr >= `CPIO_OFS_TMR0) && (rd_tofs[31:2] < 30'(NT));
  assign stat_word = {19'h0, tdone, pm_reg, array_in, din_reg};
  assign rd_hit  = rd_tmr || (rd_addr[31:2] <= 30'(`CPIO_OFS_SIG >> 2));
  assign rd_word =
    rd_tmr                     ? {14'h0, tdone[rd_tidx], tbusy[rd_tidx], 9'h0, tsel_reg[rd_tidx]} :
    (rd_addr == `CPIO_OFS_CFG)   ? {25'h0, io_dir_reg, sleep_source_cfg, sleep_enable_cfg} :
    (rd_addr == `CPIO_OFS_CTRL)  ? {19'h0, macro_reg, 7'h0, logic_sleep_request} :
    (rd_addr == `CPIO_OFS_ROUTE) ? {17'h0, route_reg} :
    (rd_addr == `CPIO_OFS_STAT)  ? stat_word :
    (rd_addr == `CPIO_OFS_SIG)   ? user_signature : 32'h0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0;
      rresp_reg  <= `CPIO_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= rd_hit ? `CPIO_RESP_OKAY : `CPIO_RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Checks. The tick gap counter exists only for the prescaler check.
  localparam int TICK_GAP = `CPIO_PRESCALE * `CPIO_MCLK_DEN / `CPIO_MCLK_NUM;
  logic [7:0] gap_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_reg <= 8'h0;
    end else begin
      gap_reg <= (tick_en || !awake) ? 8'h0 : gap_reg + 8'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_wake_hold;
    (pm_reg == CPIO_WAKE) [*4];
  endsequence
  sequence s_back_normal;
    ##1 (pm_reg == CPIO_NORMAL);
  endsequence
  // Sleep may stop the enables between two pulses, so leaving normal mode ends the wait.
  mclk_rate_a: assert property (mclk_en |=> !mclk_en ##[1:2] (mclk_en || !awake))
    else $error("master clock enable rate wrong");
  tick_gap_a: assert property (tick_en && $past(tick_en, 1) == 1'b0 && gap_reg != 8'h0
                               |-> gap_reg == 8'(TICK_GAP - 1))
    else $error("prescaled tick spacing wrong");
  wake_exit_a: assert property (pm_reg == CPIO_PDOWN && wake_s2_reg |=> pm_reg == CPIO_WAKE)
    else $error("wake level did not leave power-down");
  wake_reset_a: assert property ($rose(pm_reg == CPIO_WAKE) |-> s_wake_hold ##0 s_back_normal)
    else $error("wake reset length wrong");
  pd_float_a: assert property (pm_reg != CPIO_NORMAL |-> io_pin_oe == 5'h0 && !mclk_en)
    else $error("outputs driven while not awake");
  pd_inputs_a: assert property (pm_reg == CPIO_PDOWN |=> din_reg == 2'h0 && ioin_reg == 5'h0)
    else $error("inputs seen during power-down");
  no_sleep_a: assert property (pm_reg == CPIO_NORMAL && !sleep_enable_cfg |=> pm_reg == CPIO_NORMAL)
    else $error("slept with sleep disabled");
  pin_sleep_a: assert property (pm_reg == CPIO_NORMAL && sleep_enable_cfg && !sleep_source_cfg
                                && !wake_s2_reg |=> pm_reg == CPIO_PDOWN)
    else $error("pin source did not sleep");
  req_sleep_a: assert property (pm_reg == CPIO_NORMAL && sleep_source_cfg &&
                                (wake_s2_reg || logic_sleep_request) |=> pm_reg == CPIO_NORMAL)
    else $error("internal source slept too early");
  init_pd_a: assert property (pm_reg == CPIO_INIT && pd_cond |=> pm_reg == CPIO_PDOWN)
    else $error("startup did not go to power-down");
  in_role_a: assert property ((io_pin_oe & ~io_dir_reg) == 5'h0)
    else $error("input role pin driven");
endmodule : cpio_top

// file: cpio_pin_model.sv
// Board around the five dual-role pins: pull-ups plus external drivers.
// Assumes the device pulls a pin low only while its enable is high.
module cpio_pin_model (
  input  wire logic [4:0] io_pin_o,
  input  wire logic [4:0] io_pin_oe,
  input  wire logic [4:0] ext_drv,
  output logic      [4:0] io_pin_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // A released pin rises through its pull-up unless the board pulls it low.
  assign io_pin_i = ext_drv & ~(io_pin_oe & ~io_pin_o);
endmodule : cpio_pin_model

// file: cpio_top_tb.sv
// Self-checking bench for the clock, power-down and dual-role pin block.
// Assumes the pin model stands for the board and the bench is the bus master.
module cpio_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICK_CLK = 80;
  logic        clk = 1'h0, arst_n = 1'h0, wake_sleep_pin = 1'h1, power_down;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, din_pin = 2'h0, r;
  logic [31:0] s_axi_rdata, v;
  logic [4:0]  ext = 5'h1f, io_pin_i, io_pin_o, io_pin_oe;
  int          error_cnt = 0, tests_run = 0, cyc = 0;

  cpio_top #(.TMR_MAX_TICKS(12)) cpio_top_inst (.clk, .arst_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .wake_sleep_pin, .din_pin, .io_pin_i, .io_pin_o, .io_pin_oe,
    .power_down);
  cpio_pin_model cpio_pin_model_inst (.io_pin_o, .io_pin_oe, .ext_drv(ext), .io_pin_i);

  always #25 clk = ~clk;

  // The ceiling is several times the expected run, so only a hang reaches it.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  // Each channel holds until the rising edge that sees its ready high; the answer
  // is taken at the edge that sees its valid high, and the task returns at that edge.
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic b;
    b = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!b) begin
      @(posedge clk);
      b = s_axi_bvalid && s_axi_bready;
      r = s_axi_bresp;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end
  endtask : wr

  task automatic rd(input logic [31:0] a);
    logic b;
    b = 1'h0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    while (!b) begin
      @(posedge clk);
      b = s_axi_rvalid && s_axi_rready;
      v = s_axi_rdata;
      r = s_axi_rresp;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end
  endtask : rd

  task automatic wt(input logic e);
    int n;
    n = 0;
    while (power_down !== e && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk(power_down, e, "power mode");
    @(posedge clk);
  endtask : wt

  task automatic t_reset();
    rd(32'h0);
    chk(v, 32'h0, "cfg reset");
    rd(32'h10);
    chk(v, 32'h0, "sig reset");
    chk(r, 2'h0, "read okay");
    rd(32'h8);
    chk(v, 32'h7fff, "route reset");
    rd(32'h40);
    chk(r, 2'h2, "unmapped read");
    wake_sleep_pin <= 1'h0;
    repeat (20) @(posedge clk);
    chk(power_down, 1'h0, "sleep disabled");
    wake_sleep_pin <= 1'h1;
    wr(32'h10, 32'ha5c3_0f12);
    chk(r, 2'h0, "write okay");
    wr(32'h40, 32'h1);
    chk(r, 2'h2, "unmapped write");
    rd(32'h10);
    chk(v, 32'ha5c3_0f12, "signature");
    $display("reset test done");
  endtask : t_reset

  task automatic t_pins();
    din_pin <= 2'h2;
    ext <= 5'h1e;
    wr(32'h0, 32'h4);
    wr(32'h4, 32'h100);
    repeat (10) @(posedge clk);
    rd(32'hc);
    chk(v[6:0], 7'h7e, "array inputs");
    chk(io_pin_oe, 5'h00, "released");
    chk(io_pin_o, 5'h00, "open drain");
    wr(32'h4, 32'h0);
    chk(io_pin_oe, 5'h01, "output role");
    wr(32'h0, 32'h14);
    wr(32'h8, 32'h7e7f);
    wr(32'h4, 32'h1d00);
    chk(io_pin_oe, 5'h04, "rerouted");
    wr(32'h8, 32'h7fff);
    ext <= 5'h1f;
    $display("pin test done");
  endtask : t_pins

  task automatic t_pd_pin();
    wr(32'h0, 32'h5);
    wr(32'h4, 32'h1e01);
    wake_sleep_pin <= 1'h0;
    wt(1'h1);
    chk(io_pin_oe, 5'h00, "outputs float");
    rd(32'h0);
    chk(v, 32'h5, "cfg kept");
    wake_sleep_pin <= 1'h1;
    wt(1'h0);
    repeat (8) @(posedge clk);
    rd(32'h4);
    chk(v, 32'h0, "ctrl after wake");
    chk(io_pin_oe, 5'h01, "restart state");
    rd(32'hc);
    chk(v[8:7], 2'h1, "normal state");
    $display("pin sleep test done");
  endtask : t_pd_pin

  task automatic t_pd_int();
    wr(32'h0, 32'h7);
    wr(32'h4, 32'h1);
    wake_sleep_pin <= 1'h0;
    repeat (20) @(posedge clk);
    chk(power_down, 1'h0, "request high");
    wr(32'h4, 32'h0);
    wt(1'h1);
    din_pin <= 2'h1;
    wr(32'h4, 32'h1);
    repeat (10) @(posedge clk);
    chk(power_down, 1'h1, "request cannot wake");
    rd(32'hc);
    chk(v[1:0], 2'h0, "inputs ignored");
    wake_sleep_pin <= 1'h1;
    wt(1'h0);
    wr(32'h0, 32'h0);
    $display("internal sleep test done");
  endtask : t_pd_int

  task automatic t_timer(input int t, input logic [6:0] s, input int ticks);
    int c0;
    logic [31:0] a;
    a = 32'h14 + 32'(4 * t);
    wr(a, {23'h0, 1'h1, 1'h0, s});
    c0 = cyc;
    rd(a);
    chk(v[16], 1'h1, "busy");
    while (!v[17]) rd(a);
    chk(32'(cyc - c0 - ticks * TICK_CLK + 90) <= 32'd180, 1'h1, "timeout");
    rd(32'hc);
    chk(v[9 + t], 1'h1, "done flag");
    $display("timer test done");
  endtask : t_timer

  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'h1;
    @(posedge clk);
    t_reset();
    t_pins();
    t_pd_pin();
    t_pd_int();
    t_timer(0, 7'h00, 8);
    t_timer(3, 7'h01, 12);
    results();
  end
endmodule : cpio_top_tb
